// file: ldc_display_ctrl.sv
`timescale 1ns/1ps
// How it works
// [RULE_01] Panel image, cursor and layers appear only while the display on bit is 1.
// [RULE_02] Display on bit overrides every block and cursor appearance field.
// [RULE_03] Host waits at least 50 ms after display off before switching on.
// [RULE_04] Third block field bits 7-6: blank, steady, flash /32, flash /4.
// [RULE_05] Second block field bits 5-4, same code, also drives fourth in dual.
// [RULE_06] First block field bits 3-2 uses the same four-way code.
// [RULE_07] Cursor field bits 1-0: hidden, steady, flash /32, flash /64.
// [RULE_08] A flashing cursor is visible 70 % and hidden 30 % of each period; the code shows it 22 of 32 and 44 of 64 frames.
// [RULE_09] Memory write with cursor hidden re-enables it and advances its position.
// [RULE_10] Memory read advances the cursor position but leaves it hidden.
// [RULE_11] First block origin is 15 bits: low register plus high bits 6-0.
// [RULE_12] Host writes the low origin byte before the high one.
// [RULE_13] Origin changes only when the high byte is written.
// [RULE_14] High bit 7 defers a new origin until scroll update is 1.
// [RULE_15] First block line count register holds height in lines minus one.
// [RULE_16] Second block origin splits the same way with its own defer bit.
// [RULE_17] Display switch command parameter loads the appearance register.
// [RULE_18] Scroll command parameters load in order from first block low onward.
// [RULE_19] Flash timing comes from a free-running frame counter.
module ldc_display_ctrl
   import ldc_pkg::*;
#(
   parameter logic [7:0] CMD_DISPLAY_SWITCH = ldc_pkg::CMD_DISP_DEFAULT,
   parameter logic [7:0] CMD_SCROLL = ldc_pkg::CMD_SCROLL_DEFAULT
) (
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SRST,
   // Direct register port
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   output logic [7:0] O_REG_RDATA,
   // Indirect command and parameter port
   input wire logic I_CMD_WR,
   input wire logic [7:0] I_CMD_DATA,
   input wire logic I_PARAM_WR,
   input wire logic [7:0] I_PARAM_DATA,
   // Display memory access events and cursor position load
   input wire logic I_MEM_WR,
   input wire logic I_MEM_RD,
   input wire logic I_CURSOR_LOAD,
   input wire logic [ldc_pkg::ORIGIN_W-1:0] I_CURSOR_ADDR,
   // Timing and mode inputs from the display engine
   input wire logic I_FRAME_TICK,
   input wire logic I_SCROLL_UPDATE,
   input wire logic I_DUAL_PANEL,
   // Display engine controls
   output logic O_DISP_ON,
   output logic O_BLK1_SHOW,
   output logic O_BLK2_SHOW,
   output logic O_BLK3_SHOW,
   output logic O_BLK4_SHOW,
   output logic O_CURSOR_SHOW,
   output logic O_CURSOR_ENABLED,
   output logic [ldc_pkg::ORIGIN_W-1:0] O_CURSOR_ADDR,
   output logic [ldc_pkg::ORIGIN_W-1:0] O_BLK1_ORIGIN,
   output logic [ldc_pkg::ORIGIN_W-1:0] O_BLK2_ORIGIN,
   output logic [7:0] O_BLK1_LINES
);

   import ldc_pkg::*;

   // Parameter sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DISP_PARAM = 3'b010,
      ST_SCROLL_PARAM = 3'b100
   } ldc_state_e;

   localparam logic [7:0] SCROLL_SPAN = ADDR_SCROLL_LAST - ADDR_B1_LO;
   localparam logic [7:0] PTR_ONE = 8'h01;
   localparam logic [ORIGIN_W-1:0] CUR_STEP = ORIGIN_W'(1);

   ldc_state_e st;
   ldc_state_e next_st;
   logic [7:0] scroll_ptr;
   logic [7:0] next_scroll_ptr;
   logic disp_on;
   logic [7:0] attr;
   logic [7:0] next_attr;
   logic [7:0] lines;
   logic [ORIGIN_W-1:0] cursor_addr;
   logic slow_on;
   logic fast_on;
   logic cur_slow_on;
   logic cur_slowest_on;
   logic [7:0] rd_value;

   // Per-block origin state gathered for read-back and outputs
   wire [7:0] blk_lo [NUM_BLOCKS];
   wire [7:0] blk_hi [NUM_BLOCKS];
   wire [ORIGIN_W-1:0] blk_origin [NUM_BLOCKS];

   // Parameter bytes become register writes; a direct write in the same cycle takes the slot
   wire param_hit = I_PARAM_WR && (st != ST_IDLE);
   wire [7:0] param_addr = (st == ST_DISP_PARAM) ? ADDR_ATTR : 8'(ADDR_B1_LO + scroll_ptr); // RULE_17 RULE_18
   wire eff_wr = I_REG_WR || param_hit;
   wire [7:0] eff_addr = I_REG_WR ? I_REG_ADDR : param_addr;
   wire [7:0] eff_data = I_REG_WR ? I_REG_WDATA : I_PARAM_DATA;

   // Write decode
   wire wr_disp_on = eff_wr && (eff_addr == ADDR_DISP_ON);
   wire wr_attr = eff_wr && (eff_addr == ADDR_ATTR);
   wire wr_lines = eff_wr && (eff_addr == ADDR_B1_LINES);

   // Appearance fields
   wire [1:0] app_b3 = attr[ATTR_B3_LSB +: 2];
   wire [1:0] app_b2 = attr[ATTR_B2_LSB +: 2];
   wire [1:0] app_b1 = attr[ATTR_B1_LSB +: 2];
   wire [1:0] app_cur = attr[ATTR_CUR_LSB +: 2];
   wire cursor_hidden = (app_cur == APP_BLANK);

   // Block visibility for one appearance field
   function automatic logic block_vis(input logic [1:0] app, input logic slow, input logic fast);
      logic vis;
      vis = 1'b0;
      case (app)
         APP_BLANK: vis = 1'b0;
         APP_STEADY: vis = 1'b1;
         APP_SLOW: vis = slow;
         default: vis = fast;
      endcase
      return vis;
   endfunction

   // Cursor differs from blocks in its slowest rate and in its 70 % on-share at the slow rate
   function automatic logic cursor_vis(input logic [1:0] app, input logic slow, input logic slowest);
      logic vis;
      vis = 1'b0;
      case (app)
         APP_BLANK: vis = 1'b0;
         APP_STEADY: vis = 1'b1;
         APP_SLOW: vis = slow;
         default: vis = slowest;
      endcase
      return vis;
   endfunction

   // Flash phase generator
   ldc_flash #(
      .CNT_W(FRAME_CNT_W)
   ) u_flash (
      .i_clk(I_CORE_CLK),
      .i_srst(I_SRST),
      .i_frame_tick(I_FRAME_TICK),
      .o_slow_on(slow_on),
      .o_fast_on(fast_on),
      .o_cur_slow_on(cur_slow_on),
      .o_cur_slowest_on(cur_slowest_on)
   );

   // Command sequencer: a new display switch or scroll command always restarts parameter loading
   always_comb begin
      next_st = st;
      next_scroll_ptr = scroll_ptr;
      case (st)
         ST_IDLE: begin
            next_st = ST_IDLE;
         end
         ST_DISP_PARAM: begin
            if (param_hit) begin
               next_st = ST_IDLE; // RULE_17
            end
         end
         ST_SCROLL_PARAM: begin
            if (param_hit) begin
               if (scroll_ptr == SCROLL_SPAN) begin
                  next_st = ST_IDLE; // RULE_18
               end else begin
                  next_scroll_ptr = scroll_ptr + PTR_ONE; // RULE_18
               end
            end
         end
         default: begin
            next_st = ST_IDLE;
         end
      endcase
      if (I_CMD_WR) begin
         next_scroll_ptr = '0;
         if (I_CMD_DATA == CMD_DISPLAY_SWITCH) begin
            next_st = ST_DISP_PARAM;
         end else if (I_CMD_DATA == CMD_SCROLL) begin
            next_st = ST_SCROLL_PARAM;
         end else begin
            next_st = ST_IDLE;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         st <= ST_IDLE;
         scroll_ptr <= '0;
      end else begin
         st <= next_st;
         scroll_ptr <= next_scroll_ptr;
      end
   end

   // Appearance register; a memory write re-enabling the cursor beats a clearing host write
   always_comb begin
      next_attr = wr_attr ? eff_data : attr;
      if (I_MEM_WR && cursor_hidden) begin
         next_attr[ATTR_CUR_LSB +: 2] = APP_STEADY; // RULE_09
      end
   end

   // Display on, appearance and line count registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         disp_on <= RST_DISP_ON[DISP_ON_BIT];
         attr <= RST_ATTR;
         lines <= RST_LINES;
      end else begin
         if (wr_disp_on) begin
            disp_on <= eff_data[DISP_ON_BIT];
         end
         attr <= next_attr;
         if (wr_lines) begin
            lines <= eff_data; // RULE_15
         end
      end
   end

   // Cursor position: reads and writes both step it, a load takes priority
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         cursor_addr <= '0;
      end else if (I_CURSOR_LOAD) begin
         cursor_addr <= I_CURSOR_ADDR;
      end else if (I_MEM_WR || I_MEM_RD) begin
         cursor_addr <= cursor_addr + CUR_STEP; // RULE_09 RULE_10
      end
   end

   // Origin staging per block; a deferred value waits for the scroll update level
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_blk
         localparam logic [7:0] LO_A = 8'(ADDR_B1_LO + BLOCK_STRIDE * gi);
         localparam logic [7:0] HI_A = 8'(ADDR_B1_HI + BLOCK_STRIDE * gi);
         logic [7:0] lo;
         logic [7:0] hi;
         logic [ORIGIN_W-1:0] staged;
         logic [ORIGIN_W-1:0] origin;
         logic pend;
         wire wr_lo = eff_wr && (eff_addr == LO_A);
         wire wr_hi = eff_wr && (eff_addr == HI_A);
         wire [ORIGIN_W-1:0] joined = {eff_data[ORIGIN_HI_W-1:0], lo}; // RULE_11 RULE_16

         always_ff @(posedge I_CORE_CLK) begin
            if (I_SRST) begin
               lo <= RST_ORIGIN_BYTE;
               hi <= RST_ORIGIN_BYTE;
               staged <= '0;
               origin <= '0;
               pend <= 1'b0;
            end else begin
               if (wr_lo) begin
                  lo <= eff_data; // RULE_13
               end
               if (wr_hi) begin
                  hi <= eff_data;
                  staged <= joined;
               end
               if (wr_hi && !eff_data[DEFER_BIT]) begin
                  origin <= joined; // RULE_13 RULE_14
                  pend <= 1'b0;
               end else if (wr_hi) begin
                  pend <= 1'b1; // RULE_14
               end else if (pend && I_SCROLL_UPDATE) begin
                  origin <= staged; // RULE_14 RULE_16
                  pend <= 1'b0;
               end
            end
         end

         assign blk_lo[gi] = lo;
         assign blk_hi[gi] = hi;
         assign blk_origin[gi] = origin;
      end
   endgenerate

   // Read-back mux; reserved bits and unmapped offsets read as zero
   always_comb begin
      if (I_REG_ADDR == ADDR_DISP_ON) begin
         rd_value = {7'h00, disp_on};
      end else if (I_REG_ADDR == ADDR_ATTR) begin
         rd_value = attr;
      end else if (I_REG_ADDR == ADDR_B1_LO) begin
         rd_value = blk_lo[0];
      end else if (I_REG_ADDR == ADDR_B1_HI) begin
         rd_value = blk_hi[0];
      end else if (I_REG_ADDR == ADDR_B1_LINES) begin
         rd_value = lines;
      end else if (I_REG_ADDR == ADDR_B2_LO) begin
         rd_value = blk_lo[1];
      end else if (I_REG_ADDR == ADDR_B2_HI) begin
         rd_value = blk_hi[1];
      end else begin
         rd_value = RD_UNMAPPED;
      end
   end

   // Read data is captured on the strobe and held until the next read
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_REG_RDATA <= RD_UNMAPPED;
      end else if (I_REG_RD) begin
         O_REG_RDATA <= rd_value;
      end
   end

   // Visibility outputs; display on gates everything so no layer leaks while off
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_DISP_ON <= 1'b0;
         O_BLK1_SHOW <= 1'b0;
         O_BLK2_SHOW <= 1'b0;
         O_BLK3_SHOW <= 1'b0;
         O_BLK4_SHOW <= 1'b0;
         O_CURSOR_SHOW <= 1'b0;
      end else begin
         O_DISP_ON <= disp_on; // RULE_01
         O_BLK1_SHOW <= disp_on && block_vis(app_b1, slow_on, fast_on); // RULE_02 RULE_06
         O_BLK2_SHOW <= disp_on && block_vis(app_b2, slow_on, fast_on); // RULE_02 RULE_05
         O_BLK3_SHOW <= disp_on && block_vis(app_b3, slow_on, fast_on); // RULE_02 RULE_04
         O_BLK4_SHOW <= disp_on && I_DUAL_PANEL && block_vis(app_b2, slow_on, fast_on); // RULE_05
         O_CURSOR_SHOW <= disp_on && cursor_vis(app_cur, cur_slow_on, cur_slowest_on); // RULE_01 RULE_07
      end
   end

   // Registered copies of state for the display engine
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_CURSOR_ENABLED <= 1'b0;
         O_CURSOR_ADDR <= '0;
         O_BLK1_ORIGIN <= '0;
         O_BLK2_ORIGIN <= '0;
         O_BLK1_LINES <= RST_LINES;
      end else begin
         O_CURSOR_ENABLED <= !cursor_hidden;
         O_CURSOR_ADDR <= cursor_addr;
         O_BLK1_ORIGIN <= blk_origin[0];
         O_BLK2_ORIGIN <= blk_origin[1];
         O_BLK1_LINES <= lines;
      end
   end

endmodule

// file: ldc_display_ctrl_asserts.sv
`timescale 1ns/1ps
module ldc_display_ctrl_asserts
   import ldc_pkg::*;
(
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SRST,
   // Host side
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [7:0] O_REG_RDATA,
   input wire logic I_MEM_WR,
   input wire logic I_MEM_RD,
   input wire logic I_CURSOR_LOAD,
   input wire logic I_SCROLL_UPDATE,
   input wire logic I_DUAL_PANEL,
   // Engine side
   input wire logic O_DISP_ON,
   input wire logic O_BLK1_SHOW,
   input wire logic O_BLK2_SHOW,
   input wire logic O_BLK3_SHOW,
   input wire logic O_BLK4_SHOW,
   input wire logic O_CURSOR_SHOW,
   input wire logic O_CURSOR_ENABLED,
   input wire logic [ldc_pkg::ORIGIN_W-1:0] O_CURSOR_ADDR,
   input wire logic [ldc_pkg::ORIGIN_W-1:0] O_BLK1_ORIGIN
);
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_SRST);

   // Host steps; registered outputs trail the taking edge by two samples
   sequence s_wr(a);
      I_REG_WR && I_REG_ADDR == a;
   endsequence
   sequence s_rd_done(ok);
      I_REG_RD && ok ##1 !I_REG_RD;
   endsequence
   sequence s_cur_step;
      (I_MEM_WR || I_MEM_RD) && !I_CURSOR_LOAD ##1 !(I_MEM_WR || I_MEM_RD || I_CURSOR_LOAD);
   endsequence

   // Two dark samples cover either output register alignment
   a_off_hides_all: assert property (
      !O_DISP_ON && !$past(O_DISP_ON) |-> !(O_BLK1_SHOW || O_BLK2_SHOW || O_BLK3_SHOW || O_BLK4_SHOW || O_CURSOR_SHOW))
      else $error("block or cursor shown while display off");
   a_single_no_blk4: assert property (
      !I_DUAL_PANEL && !$past(I_DUAL_PANEL) |-> !O_BLK4_SHOW)
      else $error("fourth block shown in single panel");
   a_dual_blk4_copy: assert property (
      I_DUAL_PANEL && $past(I_DUAL_PANEL) |-> O_BLK4_SHOW == O_BLK2_SHOW)
      else $error("fourth block differs from second");
   a_hidden_cursor_off: assert property (
      !O_CURSOR_ENABLED && !$past(O_CURSOR_ENABLED) |-> !O_CURSOR_SHOW)
      else $error("hidden cursor shown");
   a_cursor_step: assert property (
      s_cur_step |-> ##1 O_CURSOR_ADDR == ORIGIN_W'($past(O_CURSOR_ADDR) + 1))
      else $error("cursor did not advance by one");
   a_memwr_enables: assert property (
      I_MEM_WR |-> ##[1:3] O_CURSOR_ENABLED)
      else $error("memory write left cursor disabled");
   a_lo_holds_origin: assert property (
      s_wr(ADDR_B1_LO) and !I_SCROLL_UPDATE |-> ##2 $stable(O_BLK1_ORIGIN))
      else $error("origin moved on low byte write");
   a_hi_sets_origin: assert property (
      s_wr(ADDR_B1_HI) and !I_REG_WDATA[DEFER_BIT] |-> ##2 O_BLK1_ORIGIN[14:8] == $past(I_REG_WDATA[6:0], 2))
      else $error("high byte not applied to origin");
   a_defer_holds: assert property (
      s_wr(ADDR_B1_HI) and I_REG_WDATA[DEFER_BIT] && !I_SCROLL_UPDATE |-> ##2 $stable(O_BLK1_ORIGIN))
      else $error("deferred origin applied early");
   a_ctl_read_zero: assert property (
      s_rd_done(I_REG_ADDR == ADDR_DISP_ON) |-> ##1 O_REG_RDATA[7:1] == 7'h00)
      else $error("unused display control bits read set");
endmodule

bind ldc_display_ctrl ldc_display_ctrl_asserts i_ldc_display_ctrl_asserts (.I_CORE_CLK, .I_SRST, .I_REG_ADDR,
   .I_REG_WDATA, .I_REG_WR, .I_REG_RD, .O_REG_RDATA, .I_MEM_WR, .I_MEM_RD, .I_CURSOR_LOAD, .I_SCROLL_UPDATE,
   .I_DUAL_PANEL, .O_DISP_ON, .O_BLK1_SHOW, .O_BLK2_SHOW, .O_BLK3_SHOW, .O_BLK4_SHOW, .O_CURSOR_SHOW,
   .O_CURSOR_ENABLED, .O_CURSOR_ADDR, .O_BLK1_ORIGIN);

// file: ldc_display_ctrl_tb.sv
`timescale 1ns/1ps
module ldc_display_ctrl_tb;
   import ldc_pkg::*;
   localparam logic [7:0] CMD_SW = 8'h01; // Arbitrary command codes
   localparam logic [7:0] CMD_SC = 8'h02;
   logic I_CORE_CLK, I_SRST, I_REG_WR, I_REG_RD, I_CMD_WR, I_PARAM_WR, I_MEM_WR, I_MEM_RD, I_CURSOR_LOAD;
   logic [7:0] I_REG_ADDR, I_REG_WDATA, I_CMD_DATA, I_PARAM_DATA, O_REG_RDATA, O_BLK1_LINES, d;
   logic I_FRAME_TICK, I_SCROLL_UPDATE, I_DUAL_PANEL, O_DISP_ON, O_BLK1_SHOW, O_BLK2_SHOW;
   logic O_BLK3_SHOW, O_BLK4_SHOW, O_CURSOR_SHOW, O_CURSOR_ENABLED;
   logic [ORIGIN_W-1:0] I_CURSOR_ADDR, O_CURSOR_ADDR, O_BLK1_ORIGIN, O_BLK2_ORIGIN;
   int err_count, checked;
   wire [3:0] shows = {O_BLK3_SHOW, O_BLK2_SHOW, O_BLK1_SHOW, O_CURSOR_SHOW};
   wire [29:0] orgs = {O_BLK2_ORIGIN, O_BLK1_ORIGIN};
   // Visible frames and changes per 64 frames, row 0 cursor, row 1 blocks
   int on_tab[2][4] = '{'{0, 64, 44, 44}, '{0, 64, 32, 32}};
   int chg_tab[2][4] = '{'{0, 0, 4, 2}, '{0, 0, 4, 32}};
   logic [7:0] prm[5] = '{8'h11, 8'h02, 8'h05, 8'h22, 8'h03};

   initial begin
      I_CORE_CLK = 1'b0;
      forever #2 I_CORE_CLK = ~I_CORE_CLK;
   end

   ldc_display_ctrl #(.CMD_DISPLAY_SWITCH(CMD_SW), .CMD_SCROLL(CMD_SC)) i_ldc_display_ctrl (.I_CORE_CLK, .I_SRST,
      .I_REG_ADDR, .I_REG_WDATA, .I_REG_WR, .I_REG_RD, .O_REG_RDATA, .I_CMD_WR, .I_CMD_DATA, .I_PARAM_WR,
      .I_PARAM_DATA, .I_MEM_WR, .I_MEM_RD, .I_CURSOR_LOAD, .I_CURSOR_ADDR, .I_FRAME_TICK, .I_SCROLL_UPDATE,
      .I_DUAL_PANEL, .O_DISP_ON, .O_BLK1_SHOW, .O_BLK2_SHOW, .O_BLK3_SHOW, .O_BLK4_SHOW, .O_CURSOR_SHOW,
      .O_CURSOR_ENABLED, .O_CURSOR_ADDR, .O_BLK1_ORIGIN, .O_BLK2_ORIGIN, .O_BLK1_LINES);

   ldc_host_model i_ldc_host_model (.i_clk(I_CORE_CLK), .o_addr(I_REG_ADDR), .o_wdata(I_REG_WDATA),
      .o_wr(I_REG_WR), .o_rd(I_REG_RD), .o_cmd_wr(I_CMD_WR), .o_cmd_data(I_CMD_DATA),
      .o_param_wr(I_PARAM_WR), .o_param_data(I_PARAM_DATA));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_ldc_host_model.put(2'd0, a, v);
   endtask

   // Read data stands from the taking edge onward
   task automatic rd(input logic [7:0] a);
      i_ldc_host_model.put(2'd1, a, 8'h00);
      @(negedge I_CORE_CLK);
      d = O_REG_RDATA;
   endtask

   // One-cycle pulse of {frame tick, cursor load, memory read, memory write}, then settle
   task automatic ev(input logic [3:0] m);
      @(negedge I_CORE_CLK);
      {I_FRAME_TICK, I_CURSOR_LOAD, I_MEM_RD, I_MEM_WR} = m;
      @(negedge I_CORE_CLK);
      {I_FRAME_TICK, I_CURSOR_LOAD, I_MEM_RD, I_MEM_WR} = 4'h0;
      repeat (4) @(negedge I_CORE_CLK);
   endtask

   // Counting over a whole 64-frame cycle makes the result independent of start phase
   task automatic flash(input int f, input int c);
      int on;
      int chg;
      logic prev;
      on = 0;
      chg = 0;
      wr(ADDR_ATTR, 8'(c << (2 * f)));
      repeat (2) ev(4'h8);
      prev = shows[f];
      repeat (64) begin
         ev(4'h8);
         on += shows[f];
         chg += (shows[f] != prev);
         prev = shows[f];
      end
      check(on, on_tab[f != 0][c]);
      check(chg, chg_tab[f != 0][c]);
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge I_CORE_CLK);
      err_count++;
      results();
   end

   initial begin
      I_SRST = 1'b1;
      {I_FRAME_TICK, I_CURSOR_LOAD, I_MEM_RD, I_MEM_WR, I_SCROLL_UPDATE, I_DUAL_PANEL} = 6'h00;
      I_CURSOR_ADDR = 15'h7fff;
      err_count = 0;
      checked = 0;
      repeat (3) @(negedge I_CORE_CLK);
      I_SRST = 1'b0;
      // Reset contents of the bank and of one unmapped offset
      for (int a = 9; a <= 16; a++) begin
         rd(8'(a));
         check(d, 8'h00);
      end
      wr(ADDR_B1_LINES, 8'hff);
      rd(ADDR_B1_LINES);
      check({d, O_BLK1_LINES}, 16'hffff);
      // Appearance set while dark must stay hidden
      wr(ADDR_ATTR, 8'h55);
      wr(ADDR_DISP_ON, 8'hfe);
      rd(ADDR_DISP_ON);
      check({d, O_DISP_ON, O_BLK4_SHOW, shows}, 14'h0000);
      // Switched on only from the reset-off state, so no off-to-on gap is needed
      wr(ADDR_DISP_ON, 8'h01);
      rd(ADDR_DISP_ON);
      check({d, O_DISP_ON, O_BLK4_SHOW, shows}, 14'h006f);
      I_DUAL_PANEL = 1'b1;
      ev(4'h0);
      check(O_BLK4_SHOW, 1'b1);
      // Low byte alone, high byte commit, then a deferred commit released by scroll update
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_B1_LO + BLOCK_STRIDE * 8'(b), 8'h34);
         ev(4'h0);
         check(orgs[15 * b +: 15], 15'h0000);
         wr(ADDR_B1_HI + BLOCK_STRIDE * 8'(b), 8'h12);
         ev(4'h0);
         check(orgs[15 * b +: 15], 15'h1234);
         wr(ADDR_B1_LO + BLOCK_STRIDE * 8'(b), 8'h78);
         wr(ADDR_B1_HI + BLOCK_STRIDE * 8'(b), 8'hd6);
         rd(ADDR_B1_HI + BLOCK_STRIDE * 8'(b));
         check({d, orgs[15 * b +: 15]}, {8'hd6, 15'h1234});
         I_SCROLL_UPDATE = 1'b1;
         ev(4'h0);
         I_SCROLL_UPDATE = 1'b0;
         check(orgs[15 * b +: 15], 15'h5678);
      end
      // Indirect loads, with an unknown command in between that must do nothing
      i_ldc_host_model.put(2'd2, 8'h00, CMD_SW);
      i_ldc_host_model.put(2'd3, 8'h00, 8'he4);
      i_ldc_host_model.put(2'd2, 8'h00, 8'hee);
      i_ldc_host_model.put(2'd3, 8'h00, 8'h00);
      rd(ADDR_ATTR);
      check(d, 8'he4);
      i_ldc_host_model.put(2'd2, 8'h00, CMD_SC);
      foreach (prm[i]) i_ldc_host_model.put(2'd3, 8'h00, prm[i]);
      ev(4'h0);
      check({O_BLK1_LINES, O_BLK1_ORIGIN}, {8'h05, 15'h0211});
      check(O_BLK2_ORIGIN, 15'h0322);
      // Every code of every appearance field
      for (int f = 0; f < 4; f++) begin
         for (int c = 0; c < 4; c++) begin
            flash(f, c);
         end
      end
      // Memory events on a hidden cursor, starting at the top of the address range
      wr(ADDR_ATTR, 8'h00);
      ev(4'h4);
      check(O_CURSOR_ADDR, 15'h7fff);
      ev(4'h2);
      check({O_CURSOR_ENABLED, O_CURSOR_ADDR}, 16'h0000);
      ev(4'h1);
      rd(ADDR_ATTR);
      check({d, O_CURSOR_ENABLED, O_CURSOR_ADDR}, 24'h018001);
      wr(ADDR_ATTR, 8'h55);
      wr(ADDR_DISP_ON, 8'h00);
      ev(4'h0);
      check({O_DISP_ON, O_BLK4_SHOW, shows}, 6'h00);
      results();
   end
endmodule

// file: ldc_flash.sv
`timescale 1ns/1ps
module ldc_flash
   import ldc_pkg::*;
#(
   parameter int CNT_W = FRAME_CNT_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Frame boundary pulse
   input wire logic i_frame_tick,
   // Visibility phases
   output logic o_slow_on,
   output logic o_fast_on,
   output logic o_cur_slow_on,
   output logic o_cur_slowest_on
);

   // Frames of each 70 % on-share, rounded down
   localparam logic [CNT_W-1:0] CUR_ON_SLOW = CNT_W'((FLASH_SLOW_DIV * CUR_ON_PCT) / 100);
   localparam logic [CNT_W-1:0] CUR_ON_SLOWEST = CNT_W'((CUR_SLOWEST_DIV * CUR_ON_PCT) / 100);
   localparam logic [CNT_W-1:0] SLOW_MASK = CNT_W'(FLASH_SLOW_DIV - 1);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   logic [CNT_W-1:0] frame_cnt;
   logic [CNT_W-1:0] slow_phase;

   assign slow_phase = frame_cnt & SLOW_MASK;

   // Free-running frame count; phases only move on frame boundaries
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         frame_cnt <= '0;
      end else if (i_frame_tick) begin
         frame_cnt <= frame_cnt + ONE; // RULE_19
      end
   end

   // Half-period on for block flashing, 70 % on for cursor flashing
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_slow_on <= 1'b1;
         o_fast_on <= 1'b1;
         o_cur_slow_on <= 1'b1;
         o_cur_slowest_on <= 1'b1;
      end else begin
         o_slow_on <= slow_phase < CNT_W'(FLASH_SLOW_DIV / 2); // RULE_19
         o_fast_on <= (frame_cnt & CNT_W'(FLASH_FAST_DIV - 1)) < CNT_W'(FLASH_FAST_DIV / 2);
         o_cur_slow_on <= slow_phase < CUR_ON_SLOW; // RULE_08
         o_cur_slowest_on <= frame_cnt < CUR_ON_SLOWEST; // RULE_08
      end
   end

endmodule

// file: ldc_host_model.sv
`timescale 1ns/1ps
module ldc_host_model (
   // Clock
   input wire logic i_clk,
   // Register and indirect ports
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   output logic o_cmd_wr,
   output logic [7:0] o_cmd_data,
   output logic o_param_wr,
   output logic [7:0] o_param_data
);
   // Idle bus at time zero
   initial begin
      {o_wr, o_rd, o_cmd_wr, o_param_wr} = 4'h0;
      {o_addr, o_wdata, o_cmd_data, o_param_data} = 32'h0;
   end

   // One strobe (0 write, 1 read, 2 command, 3 parameter) held over one rising edge;
   // released lines show inverted data so a stale value never matches by luck
   task automatic put(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] v);
      @(negedge i_clk);
      {o_addr, o_wdata, o_cmd_data, o_param_data} = {a, v, v, v};
      o_wr = (kind == 2'd0);
      o_rd = (kind == 2'd1);
      o_cmd_wr = (kind == 2'd2);
      o_param_wr = (kind == 2'd3);
      @(negedge i_clk);
      {o_wr, o_rd, o_cmd_wr, o_param_wr} = 4'h0;
      {o_addr, o_wdata, o_cmd_data, o_param_data} = ~{a, v, v, v};
   endtask
endmodule

// file: ldc_pkg.sv
package ldc_pkg;

   // Register offsets on the direct register port
   localparam logic [7:0] ADDR_DISP_ON = 8'h09;
   localparam logic [7:0] ADDR_ATTR = 8'h0a;
   localparam logic [7:0] ADDR_B1_LO = 8'h0b;
   localparam logic [7:0] ADDR_B1_HI = 8'h0c;
   localparam logic [7:0] ADDR_B1_LINES = 8'h0d;
   localparam logic [7:0] ADDR_B2_LO = 8'h0e;
   localparam logic [7:0] ADDR_B2_HI = 8'h0f;
   localparam logic [7:0] ADDR_SCROLL_LAST = 8'h14;

   // Offset from one block's low origin register to the next block's
   localparam logic [7:0] BLOCK_STRIDE = 8'h03;
   localparam int NUM_BLOCKS = 2;

   // Reset values
   localparam logic [7:0] RST_DISP_ON = 8'h00;
   localparam logic [7:0] RST_ATTR = 8'h00;
   localparam logic [7:0] RST_ORIGIN_BYTE = 8'h00;
   localparam logic [7:0] RST_LINES = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Field positions
   localparam int DISP_ON_BIT = 0;
   localparam int ATTR_B3_LSB = 6;
   localparam int ATTR_B2_LSB = 4;
   localparam int ATTR_B1_LSB = 2;
   localparam int ATTR_CUR_LSB = 0;
   localparam int DEFER_BIT = 7;
   localparam int ORIGIN_W = 15;
   localparam int ORIGIN_HI_W = 7;

   // Appearance encodings shared by blocks and cursor
   typedef enum logic [1:0] {
      APP_BLANK = 2'b00,
      APP_STEADY = 2'b01,
      APP_SLOW = 2'b10,
      APP_FAST = 2'b11
   } ldc_app_e;

   // Indirect command codes (arbitrary defaults, overridable at the top)
   localparam logic [7:0] CMD_DISP_DEFAULT = 8'h01;
   localparam logic [7:0] CMD_SCROLL_DEFAULT = 8'h02;

   // Flash divisions in frames and the cursor on-share in percent
   localparam int FLASH_SLOW_DIV = 32;
   localparam int FLASH_FAST_DIV = 4;
   localparam int CUR_SLOWEST_DIV = 64;
   localparam int CUR_ON_PCT = 70;
   localparam int FRAME_CNT_W = 6;

   // Least wait, in ms, the host keeps between display off and on
   localparam int DISP_OFF_WAIT_MS = 50;

endpackage
